/* File: dv/i2c_chk_asserts.sv */
/* assertions on the slave control ports
 * assumes: bound to i2c_slave_ctrl, one clock domain */
`timescale 1ns/1ps
module i2c_chk
(
	input wire mclk,
	input wire rst_b,
	input wire scl_in,
	input wire sda_in,
	input wire sda_oe,
	input wire sleep_mode,
	input wire wake_on_address_match_enable,
	input wire byte_done,
	input wire received_ack_status,
	input wire address_match_flag,
	input wire bus_busy_flag,
	input wire wake_request
);
default clocking @(posedge mclk);
endclocking
default disable iff (!rst_b);
property p_bs; $fell(sda_in) && scl_in |-> ##[1:8] bus_busy_flag; endproperty
a_bs: assert property (p_bs) else $error("busy");
property p_bc; $rose(sda_in) && scl_in |-> ##[1:8] !bus_busy_flag; endproperty
a_bc: assert property (p_bc) else $error("free");
property p_om; sda_oe |-> address_match_flag; endproperty
a_om: assert property (p_om) else $error("drive");
property p_os; $changed(sda_oe) |-> !scl_in; endproperty
a_os: assert property (p_os) else $error("edge");
property p_nk; byte_done && received_ack_status |-> !sda_oe [*8] ##1 !sda_oe [*8] ##1 !sda_oe [*8]; endproperty
a_nk: assert property (p_nk) else $error("nack");
property p_dn; byte_done |=> !byte_done; endproperty
a_dn: assert property (p_dn) else $error("done");
property p_wk; $rose(wake_request) |-> sleep_mode && wake_on_address_match_enable && address_match_flag; endproperty
a_wk: assert property (p_wk) else $error("wake");
property p_wc; !wake_on_address_match_enable |-> ##[1:2] !wake_request; endproperty
a_wc: assert property (p_wc) else $error("unwake");
cover property (byte_done && received_ack_status);
cover property ($rose(address_match_flag));
cover property ($rose(wake_request));
endmodule // i2c_chk
bind i2c_slave_ctrl i2c_chk u_chk (.*);

/* File: dv/i2c_master_model.sv */
/* i2c master model, open drain sda
 * assumes: bench resolves sda with a pull-up */
`timescale 1ns/1ps
module i2c_master_model
(
	input wire sda,
	output reg scl = 1'b1,
	output reg sda_m = 1'b1
);
task start_c;
	sda_m = 1'b1;
	#20 scl = 1'b1;
	#40 sda_m = 1'b0;
	#40 scl = 1'b0;
endtask
task stop_c;
	#20 sda_m = 1'b0;
	#20 scl = 1'b1;
	#20 sda_m = 1'b1;
	#20;
endtask
task xfer(input [8:0] o, output [8:0] i);
	for (int k = 8; k >= 0; k--)
	begin
		#20 sda_m = o[k];
		#20 scl = 1'b1;
		#20 i[k] = sda;
		#20 scl = 1'b0;
	end
endtask
endmodule // i2c_master_model

/* File: dv/tb.sv */
/* bench for the slave block with a master model
 * assumes: sda pulled up */
`timescale 1ns/1ps
module tb;
reg mclk = 1'b0;
reg rst_b = 1'b0;
reg dir = 1'b0;
reg ack = 1'b0;
reg wen = 1'b1;
reg slp = 1'b1;
reg [7:0] txd = 8'h00;
reg [31:0] rs = 32'h167A;
reg [8:0] got;
reg [7:0] b;
wire scl, sm, so, oe, done, rxa, rw, mt, busy, wk;
wire [7:0] rx;
wire sda = sm & (so | ~oe);
integer n_mismatch = 0, tests_run = 0, cyc = 0, e, j;
int q[$];
i2c_master_model PM (.sda(sda), .scl(scl), .sda_m(sm));
i2c_slave_ctrl DUT (.mclk(mclk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda), .sda_out(so), .sda_oe(oe),
	.own_address(7'h2A), .slave_direction_select(dir), .outgoing_ack_select(ack), .tx_data(txd),
	.wake_on_address_match_enable(wen), .sleep_mode(slp), .rx_data(rx), .byte_done(done),
	.master_rw_direction_flag(rw), .received_ack_status(rxa), .address_match_flag(mt),
	.bus_busy_flag(busy), .wake_request(wk));
always #2.5 mclk = ~mclk;
always @(posedge mclk)
	if (++cyc == 20000)
	begin
		n_mismatch++;
		stop_test;
	end
always @(posedge mclk)
	if (mt)
		#1 dir = rw;
always @(negedge mclk)
	if (done)
	begin
		e = q.pop_front();
		if (e < 256)
			chk(rx, e, "rx");
		else
			chk(rxa, e - 256, "rxack");
	end
function [31:0] nx(input [31:0] x);
	reg [31:0] y;
	y = x ^ (x << 13);
	y = y ^ (y >> 17);
	nx = y ^ (y << 5);
endfunction
task chk(input [31:0] s, input [31:0] x, input string n);
	tests_run++;
	if (s !== x)
	begin
		n_mismatch++;
		$display("[FAIL] %s exp %0h seen %0h", n, x, s);
	end
endtask
task stop_test;
	$display("checks %0d mismatches %0d", tests_run, n_mismatch);
	if (n_mismatch == 0 && tests_run > 0)
		$display("No errors found");
	else
		$display("Errors were found");
	$finish;
endtask
task adr(input [6:0] a, input r, input m);
	PM.start_c;
	PM.xfer({a, r, 1'b1}, got);
	chk(busy, 1, "busy");
	chk(got[0], !m, "aack");
	chk(mt, m, "match");
	chk(rw, r, "rw");
endtask
task fin(input string n);
	PM.stop_c;
	#20 chk(busy, 0, "busy");
	$display("%s test done", n);
endtask
initial
begin
	repeat (16) @(posedge mclk);
	#1 rst_b = 1'b1;
	#20 adr(7'h2A, 0, 1);
	chk(wk, 1, "wake");
	for (j = 0; j < 3; j++)
	begin
		rs = nx(rs);
		ack = j == 1;
		q.push_back(rs[7:0]);
		PM.xfer({rs[7:0], 1'b1}, got);
		chk(got[0], ack, "dack");
	end
	wen = 1'b0;
	slp = 1'b0;
	fin("write");
	chk(wk, 0, "wake");
	adr(7'h2B, 0, 0);
	PM.xfer({8'h5A, 1'b1}, got);
	chk(got[0], 1, "dack");
	fin("miss");
	rs = nx(rs);
	b = rs[7:0];
	txd = b;
	adr(7'h2A, 1, 1);
	for (j = 0; j < 3; j++)
	begin
		// next byte only after the slave has loaded this one
		#20;
		rs = nx(rs);
		txd = {1'b0, rs[6:0]};
		q.push_back(256 + (j == 2));
		PM.xfer({8'hFF, j == 2}, got);
		chk(got[8:1], b, "txb");
		b = txd;
	end
	#30 chk(sda, 1, "free");
	fin("read");
	stop_test;
end
endmodule // tb

/* File: hw/i2c_pin_sync.v */
/*
 * two flip-flop synchroniser for the scl and sda pin inputs
 * assumes: pins idle high, mclk much faster than scl
 */
`timescale 1ns/1ps
`include "i2c_slave_map.vh"

module i2c_pin_sync
(
	input wire mclk,
	input wire rst_b,
	input wire [`SYNC_W-1:0] pin_in,
	output wire [`SYNC_W-1:0] pin_sync
);

reg [`SYNC_W-1:0] stage_a;
reg [`SYNC_W-1:0] stage_b;

// ----------------------------------------------------------------
// per-pin double flop
// ----------------------------------------------------------------
genvar gi;
generate
	for (gi = 0; gi < `SYNC_W; gi = gi + 1)
	begin : g_sync
		always @(posedge mclk or negedge rst_b)
		begin
			if (!rst_b)
			begin
				stage_a[gi] <= `PIN_IDLE;
				stage_b[gi] <= `PIN_IDLE;
			end
			else
			begin
				stage_a[gi] <= pin_in[gi];
				stage_b[gi] <= stage_a[gi];
			end
		end
	end
endgenerate

assign pin_sync = stage_b;

endmodule // i2c_pin_sync

/* File: hw/i2c_slave_ctrl.v */
/*
 * i2c slave byte engine with direction, acknowledge and status control
 * assumes: scl and sda come from pins (open drain, idle high); control
 * bits are held by software; the outside wire is pulled up
 */
`timescale 1ns/1ps
`include "i2c_slave_map.vh"

module i2c_slave_ctrl
(
	input wire mclk,
	input wire rst_b,
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe,
	input wire [6:0] own_address,
	input wire slave_direction_select,
	input wire outgoing_ack_select,
	input wire wake_on_address_match_enable,
	input wire sleep_mode,
	input wire [7:0] tx_data,
	output reg [7:0] rx_data,
	output reg byte_done,
	output reg master_rw_direction_flag,
	output reg received_ack_status,
	output reg address_match_flag,
	output reg bus_busy_flag,
	output reg wake_request
);

// ----------------------------------------------------------------
// pin sampling and edge detection
// ----------------------------------------------------------------
wire [`SYNC_W-1:0] pin_sync;
reg scl_q;
reg sda_q;
wire scl_s;
wire sda_s;
wire scl_rise;
wire scl_fall;
wire start_det;
wire stop_det;

i2c_pin_sync u_sync
(
	.mclk(mclk),
	.rst_b(rst_b),
	.pin_in({sda_in, scl_in}),
	.pin_sync(pin_sync)
);

assign scl_s = pin_sync[`SYNC_SCL];
assign sda_s = pin_sync[`SYNC_SDA];
assign scl_rise = scl_s & ~scl_q;
assign scl_fall = ~scl_s & scl_q;
assign start_det = scl_s & scl_q & sda_q & ~sda_s;
assign stop_det = scl_s & scl_q & ~sda_q & sda_s;

always @(posedge mclk or negedge rst_b)
begin
	if (!rst_b)
	begin
		scl_q <= 1'b1;
		sda_q <= 1'b1;
	end
	else
	begin
		scl_q <= scl_s;
		sda_q <= sda_s;
	end
end

// ----------------------------------------------------------------
// bus busy
// ----------------------------------------------------------------
always @(posedge mclk or negedge rst_b)
begin
	if (!rst_b)
		bus_busy_flag <= 1'b0;
	else if (start_det)
		bus_busy_flag <= 1'b1;
	else if (stop_det)
		bus_busy_flag <= 1'b0;
end

// ----------------------------------------------------------------
// byte state machine
// ----------------------------------------------------------------
reg [`ST_W-1:0] state;
reg [2:0] bit_cnt;
reg [7:0] shift;
reg addr_full;
wire [7:0] shift_in;

assign shift_in = {shift[6:0], sda_s};

always @(posedge mclk or negedge rst_b)
begin
	if (!rst_b)
	begin
		state <= `ST_IDLE;
		bit_cnt <= `BIT_ZERO;
		shift <= `BYTE_ZERO;
		sda_out <= 1'b0;
		sda_oe <= 1'b0;
		rx_data <= `BYTE_ZERO;
		byte_done <= 1'b0;
		master_rw_direction_flag <= 1'b0;
		received_ack_status <= 1'b0;
		address_match_flag <= 1'b0;
		addr_full <= 1'b0;
	end
	else
	begin
		byte_done <= 1'b0;
		sda_out <= 1'b0;
		if (start_det)
		begin
			state <= `ST_ADDR;
			bit_cnt <= `BIT_ZERO;
			sda_oe <= 1'b0;
			address_match_flag <= 1'b0;
			addr_full <= 1'b0;
		end
		else if (stop_det)
		begin
			state <= `ST_IDLE;
			sda_oe <= 1'b0;
		end
		else
		begin
			case (state)
				`ST_IDLE:
				begin
					sda_oe <= 1'b0;
				end
				`ST_ADDR:
				begin
					if (scl_rise)
					begin
						shift <= shift_in;
						bit_cnt <= bit_cnt + `BIT_ONE;
						if (bit_cnt == `BIT_LAST)
						begin
							address_match_flag <= (shift_in[`ADDR_HI:`ADDR_LO] == own_address);
							master_rw_direction_flag <= shift_in[`RW_POS];
							addr_full <= 1'b1;
						end
					end
					else if (scl_fall && addr_full)
					begin
						addr_full <= 1'b0;
						if (address_match_flag)
						begin
							sda_oe <= 1'b1;
							state <= `ST_AACK;
						end
						else
							state <= `ST_WAIT;
					end
				end
				`ST_AACK:
				begin
					if (scl_fall)
					begin
						bit_cnt <= `BIT_ZERO;
						// direction select picks transmit or receive
						if (slave_direction_select)
						begin
							shift <= tx_data;
							sda_oe <= ~tx_data[`MSB_POS];
							state <= `ST_TX;
						end
						else
						begin
							sda_oe <= 1'b0;
							state <= `ST_RX;
						end
					end
				end
				`ST_RX:
				begin
					if (scl_rise)
					begin
						shift <= shift_in;
						bit_cnt <= bit_cnt + `BIT_ONE;
						if (bit_cnt == `BIT_LAST)
						begin
							rx_data <= shift_in;
							byte_done <= 1'b1;
						end
					end
					else if (scl_fall && bit_cnt == `BIT_ZERO)
					begin
						// ack select driven in 9th clock
						sda_oe <= ~outgoing_ack_select;
						state <= `ST_RACK;
					end
				end
				`ST_RACK:
				begin
					if (scl_fall)
					begin
						sda_oe <= 1'b0;
						bit_cnt <= `BIT_ZERO;
						state <= `ST_RX;
					end
				end
				`ST_TX:
				begin
					if (scl_fall)
					begin
						bit_cnt <= bit_cnt + `BIT_ONE;
						if (bit_cnt == `BIT_LAST)
						begin
							sda_oe <= 1'b0;
							state <= `ST_TACK;
						end
						else
						begin
							shift <= {shift[6:0], 1'b0};
							sda_oe <= ~shift[`MSB_POS-1];
						end
					end
				end
				`ST_TACK:
				begin
					if (scl_rise)
					begin
						received_ack_status <= sda_s;
						byte_done <= 1'b1;
					end
					else if (scl_fall)
					begin
						bit_cnt <= `BIT_ZERO;
						if (!received_ack_status)
						begin
							shift <= tx_data;
							sda_oe <= ~tx_data[`MSB_POS];
							state <= `ST_TX;
						end
						else
						begin
							sda_oe <= 1'b0;
							state <= `ST_WAIT;
						end
					end
				end
				`ST_WAIT:
				begin
					sda_oe <= 1'b0;
				end
				default:
				begin
					sda_oe <= 1'b0;
					state <= `ST_IDLE;
				end
			endcase
		end
	end
end

// ----------------------------------------------------------------
// wake on address match
// ----------------------------------------------------------------
reg match_q;

always @(posedge mclk or negedge rst_b)
begin
	if (!rst_b)
	begin
		match_q <= 1'b0;
		wake_request <= 1'b0;
	end
	else
	begin
		match_q <= address_match_flag;
		if (!wake_on_address_match_enable)
			wake_request <= 1'b0;
		else if (address_match_flag && !match_q && sleep_mode)
			wake_request <= 1'b1;
	end
end

endmodule // i2c_slave_ctrl

/* File: hw/i2c_slave_map.vh */
/*
 * constants for the i2c slave direction and acknowledge control block
 * assumes: included by bare name from the design files under hw/
 */
`ifndef I2C_SLAVE_MAP_VH
`define I2C_SLAVE_MAP_VH

// ----------------------------------------------------------------
// states, one-hot
// ----------------------------------------------------------------
`define ST_W 8
`define ST_IDLE 8'h01
`define ST_ADDR 8'h02
`define ST_AACK 8'h04
`define ST_RX 8'h08
`define ST_RACK 8'h10
`define ST_TX 8'h20
`define ST_TACK 8'h40
`define ST_WAIT 8'h80

// ----------------------------------------------------------------
// byte framing
// ----------------------------------------------------------------
`define BIT_LAST 3'h7
`define BIT_ZERO 3'h0
`define BIT_ONE 3'h1
`define BYTE_ZERO 8'h00
`define MSB_POS 7
`define RW_POS 0
`define ADDR_HI 7
`define ADDR_LO 1

// ----------------------------------------------------------------
// pin synchroniser
// ----------------------------------------------------------------
`define SYNC_W 2
`define SYNC_SCL 0
`define SYNC_SDA 1
`define PIN_IDLE 1'b1

`endif
